// ===== src/eip_ext_irq.sv
// external interrupt request pins: five maskable requests, latched nmi,
// and cascade acknowledge handshake on the shared request pins
// assumes the core offers i_irq_taken as a one-cycle pulse while o_irq_valid is high
module eip_ext_irq
    import eip_pkg::*;
#(
    parameter int unsigned ACK_LOW  = ACK_LOW_CYCLES,
    parameter int unsigned ACK_QUIET = ACK_QUIET_CYCLES
) (
    input  wire logic         i_clock,
    input  wire logic         i_reset_n,
    input  wire logic         i_ext_req_zero,
    input  wire logic         i_ext_req_one,
    input  wire logic         i_ext_req_two,
    input  wire logic         i_ext_req_three,
    input  wire logic         i_ext_req_four,
    input  wire logic         i_nonmaskable_req,
    input  wire logic         i_cascade_en,
    input  wire logic         i_int_enable,
    input  wire logic [4:0]   i_source_mask,
    input  wire logic         i_irq_taken,
    output logic              o_irq_valid,
    output logic [7:0]        o_irq_type,
    output logic              o_irq_cascade,
    output logic              o_ack_zero_n,
    output logic              o_ack_zero_oe,
    output logic              o_ack_one_n,
    output logic              o_ack_one_oe
);

    if (ACK_LOW < 1 || ACK_LOW + ACK_QUIET + SYNC_LAT_CYCLES > (1 << CNT_W)) begin : g_ack_check
        $error("eip_ext_irq: acknowledge timing does not fit the counter");
    end

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic [5:0]        pin_lvl;
    logic [4:0]        req_s;
    logic              nmi_s;

    eip_pin_sync #(
        .WIDTH (6)
    ) u_sync (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_pins    ({i_nonmaskable_req, i_ext_req_four, i_ext_req_three,
                     i_ext_req_two, i_ext_req_one, i_ext_req_zero}),
        .o_level   (pin_lvl)
    );

    assign req_s = pin_lvl[4:0];
    assign nmi_s = pin_lvl[5];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    eip_state_e        st_ff;
    logic [2:0]        src_ff;
    logic [CNT_W-1:0]  cnt_ff;
    logic              cascade_ff;
    logic              nmi_prev_ff;
    logic              nmi_pend_ff;
    logic              valid_ff;
    logic [7:0]        type_ff;
    logic              casc_src_ff;
    logic              ack_zero_n_ff;
    logic              ack_one_n_ff;

    logic [4:0]        eligible;
    logic              any_req;
    logic [2:0]        pick;
    logic              taken;
    logic              nmi_rise;
    logic              casc_ack;

    function automatic logic [7:0] type_of(input logic [2:0] src);
        case (src)
            SRC_REQ_ZERO: type_of = TYPE_REQ_ZERO;
            SRC_REQ_ONE:  type_of = TYPE_REQ_ONE;
            SRC_REQ_TWO:  type_of = TYPE_REQ_TWO;
            SRC_REQ_THR:  type_of = TYPE_REQ_THR;
            SRC_REQ_FOUR: type_of = TYPE_REQ_FOUR;
            default:      type_of = TYPE_NMI;
        endcase
    endfunction

    // ------------------------------------------------------------
    // request qualification and priority (zero highest)
    // ------------------------------------------------------------
    always_comb begin
        eligible = req_s & ~i_source_mask & {NUM_REQ{i_int_enable}};
        // in cascade mode the pins of requests two and three carry the acknowledges
        if (cascade_ff) begin
            eligible[SRC_REQ_TWO] = 1'b0;
            eligible[SRC_REQ_THR] = 1'b0;
        end
        any_req = |eligible;
        pick    = SRC_REQ_FOUR;
        for (int i = NUM_REQ - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                pick = 3'(i);
            end
        end
    end

    assign taken    = (st_ff == ST_OFFER) && i_irq_taken;
    assign nmi_rise = nmi_s && !nmi_prev_ff;
    assign casc_ack = cascade_ff && (src_ff == SRC_REQ_ZERO || src_ff == SRC_REQ_ONE);

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            cascade_ff  <= 1'b0;
            nmi_prev_ff <= 1'b0;
        end else begin
            cascade_ff  <= i_cascade_en;
            nmi_prev_ff <= nmi_s;
        end
    end

    // ------------------------------------------------------------
    // nmi latch: a new edge wins over the clear by service
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            nmi_pend_ff <= 1'b0;
        end else if (nmi_rise) begin
            nmi_pend_ff <= 1'b1;
        end else if (taken && src_ff == SRC_NMI) begin
            nmi_pend_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // offer / acknowledge sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            st_ff       <= ST_IDLE;
            src_ff      <= SRC_NMI;
            cnt_ff      <= '0;
            valid_ff    <= 1'b0;
            type_ff     <= TYPE_NMI;
            casc_src_ff <= 1'b0;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    if (nmi_pend_ff) begin
                        // not gated by the enable or the source mask
                        st_ff    <= ST_OFFER;
                        src_ff   <= SRC_NMI;
                        type_ff  <= TYPE_NMI;
                        valid_ff <= 1'b1;
                    end else if (any_req) begin
                        st_ff       <= ST_OFFER;
                        src_ff      <= pick;
                        type_ff     <= type_of(pick);
                        valid_ff    <= 1'b1;
                        casc_src_ff <= cascade_ff && (pick == SRC_REQ_ZERO ||
                                                      pick == SRC_REQ_ONE);
                    end
                end
                ST_OFFER: begin
                    if (taken) begin
                        valid_ff    <= 1'b0;
                        casc_src_ff <= 1'b0;
                        cnt_ff      <= '0;
                        st_ff       <= casc_ack ? ST_ACK : ST_IDLE;
                    end else if (nmi_pend_ff && src_ff != SRC_NMI) begin
                        // nmi preempts a maskable request still on offer
                        src_ff      <= SRC_NMI;
                        type_ff     <= TYPE_NMI;
                        casc_src_ff <= 1'b0;
                    end else if (src_ff != SRC_NMI && !eligible[src_ff]) begin
                        // withdrawn or masked before the core took it
                        valid_ff    <= 1'b0;
                        casc_src_ff <= 1'b0;
                        st_ff       <= ST_IDLE;
                    end
                end
                ST_ACK: begin
                    // the quiet tail relies on the controller dropping its request
                    cnt_ff <= cnt_ff + 1'b1;
                    // also wait out the synchroniser, else the stale level is offered again
                    if (cnt_ff == CNT_W'(ACK_LOW + ACK_QUIET + SYNC_LAT_CYCLES - 1)) begin
                        st_ff <= ST_IDLE;
                    end
                end
                default: begin
                    st_ff    <= ST_IDLE;
                    valid_ff <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // acknowledge pins
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            ack_zero_n_ff <= 1'b1;
            ack_one_n_ff  <= 1'b1;
        end else if (taken && casc_ack) begin
            ack_zero_n_ff <= !(src_ff == SRC_REQ_ZERO);
            ack_one_n_ff  <= !(src_ff == SRC_REQ_ONE);
        end else if (st_ff == ST_ACK && cnt_ff == CNT_W'(ACK_LOW - 1)) begin
            ack_zero_n_ff <= 1'b1;
            ack_one_n_ff  <= 1'b1;
        end
    end

    assign o_irq_valid   = valid_ff;
    assign o_irq_type    = type_ff;
    assign o_irq_cascade = casc_src_ff;
    assign o_ack_zero_n  = ack_zero_n_ff;
    assign o_ack_one_n   = ack_one_n_ff;
    // drivers follow the registered cascade mode
    assign o_ack_zero_oe = cascade_ff;
    assign o_ack_one_oe  = cascade_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    sequence s_ack_pulse_zero;
        !o_ack_zero_n [*2] ##1 o_ack_zero_n;
    endsequence

    sequence s_ack_pulse_one;
        !o_ack_one_n [*2] ##1 o_ack_one_n;
    endsequence

    type_low_a: assert property ($rose(o_irq_valid) && o_irq_type == TYPE_REQ_ZERO
        |-> $past(eligible[0])) else $error("type 12 offered without request zero");
    type_mid_a: assert property ($rose(o_irq_valid) && o_irq_type == TYPE_REQ_TWO
        |-> $past(eligible[2]) && !cascade_ff) else $error("type 14 offered wrongly");
    type_high_a: assert property ($rose(o_irq_valid) && o_irq_type == TYPE_REQ_FOUR
        |-> $past(eligible[4] && !(|eligible[3:0]))) else $error("type 17 misrouted");
    cascade_pins_a: assert property (!i_cascade_en |=> !o_ack_zero_oe && !o_ack_one_oe
        && o_ack_zero_n && o_ack_one_n) else $error("acknowledge driven outside cascade");
    ack_zero_a: assert property (taken && cascade_ff && src_ff == SRC_REQ_ZERO
        |=> s_ack_pulse_zero) else $error("acknowledge zero pulse wrong");
    ack_one_a: assert property (taken && cascade_ff && src_ff == SRC_REQ_ONE
        |=> s_ack_pulse_one) else $error("acknowledge one pulse wrong");
    nmi_offer_a: assert property (st_ff == ST_IDLE && nmi_pend_ff
        |=> o_irq_valid && o_irq_type == TYPE_NMI) else $error("nmi not offered as type 2");
    nmi_latch_a: assert property (nmi_rise
        |=> nmi_pend_ff) else $error("nmi edge lost");

endmodule

// ===== src/eip_pkg.sv
// constants, types and timing for the external interrupt pin logic
// assumes a single 10 MHz core clock with synchronous active-low reset
package eip_pkg;

    // ------------------------------------------------------------
    // request sources and interrupt types
    // ------------------------------------------------------------
    localparam int unsigned   NUM_REQ      = 5;
    localparam logic [2:0]    SRC_REQ_ZERO = 3'h0;
    localparam logic [2:0]    SRC_REQ_ONE  = 3'h1;
    localparam logic [2:0]    SRC_REQ_TWO  = 3'h2;
    localparam logic [2:0]    SRC_REQ_THR  = 3'h3;
    localparam logic [2:0]    SRC_REQ_FOUR = 3'h4;
    localparam logic [2:0]    SRC_NMI      = 3'h5;

    localparam logic [7:0]    TYPE_NMI      = 8'h02;
    localparam logic [7:0]    TYPE_REQ_ZERO = 8'h0C;
    localparam logic [7:0]    TYPE_REQ_ONE  = 8'h0D;
    localparam logic [7:0]    TYPE_REQ_TWO  = 8'h0E;
    localparam logic [7:0]    TYPE_REQ_THR  = 8'h0F;
    localparam logic [7:0]    TYPE_REQ_FOUR = 8'h11;

    // ------------------------------------------------------------
    // timing of the acknowledge pulse
    // ------------------------------------------------------------
    localparam int unsigned   CLK_PERIOD_NS   = 100;
    localparam int unsigned   ACK_LOW_NS      = 200;
    // least time, rounded up to whole cycles
    localparam int unsigned   ACK_LOW_CYCLES  = (ACK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // time the controller is given to drop its request after the pulse
    localparam int unsigned   ACK_QUIET_CYCLES = 4;
    // pin to qualified level: three sync stages plus the agreement flop
    localparam int unsigned   SYNC_LAT_CYCLES  = 4;
    localparam int unsigned   CNT_W           = 4;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_OFFER = 2'b01,
        ST_ACK   = 2'b10
    } eip_state_e;

endpackage

// ===== src/eip_pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pin inputs and one core clock
module eip_pin_sync #(
    parameter int unsigned WIDTH = 6
) (
    input  wire logic             i_clock,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_pins,
    output logic      [WIDTH-1:0] o_level
);

    if (WIDTH < 1) begin : g_width_check
        $error("eip_pin_sync: WIDTH must be at least 1");
    end

    // ------------------------------------------------------------
    // per-bit chain; stage one feeds stage two only
    // ------------------------------------------------------------
    for (genvar g = 0; g < WIDTH; g++) begin : g_bit
        logic s1_ff;
        logic s2_ff;
        logic s3_ff;
        logic lvl_ff;

        always_ff @(posedge i_clock) begin
            if (!i_reset_n) begin
                s1_ff  <= 1'b0;
                s2_ff  <= 1'b0;
                s3_ff  <= 1'b0;
                lvl_ff <= 1'b0;
            end else begin
                s1_ff <= i_pins[g];
                s2_ff <= s1_ff;
                s3_ff <= s2_ff;
                // a change counts only once stages two and three agree
                if (s2_ff == s3_ff) begin
                    lvl_ff <= s3_ff;
                end
            end
        end

        assign o_level[g] = lvl_ff;
    end

endmodule

// ===== verification/eip_cascade_ctrl.sv
// model of two cascaded interrupt controllers on request pins zero and one
// assumes the acknowledge inputs read high whenever the device is not driving them
module eip_cascade_ctrl (
    input  wire logic       i_clock,
    input  wire logic       i_reset_n,
    input  wire logic [1:0] i_raise,
    input  wire logic [1:0] i_hold,
    input  wire logic [1:0] i_ack_n,
    output logic      [1:0] o_req
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] acked_ff;
    logic [1:0] wait_ff [2];

    // ------------------------------------------------------------
    // request held until acknowledged, then dropped after i_hold cycles
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        for (int p = 0; p < 2; p++) begin
            if (!i_reset_n) begin
                o_req[p]    <= 1'b0;
                acked_ff[p] <= 1'b0;
                wait_ff[p]  <= 2'd0;
            end else if (i_raise[p]) begin
                o_req[p]    <= 1'b1;
                acked_ff[p] <= 1'b0;
            end else if (o_req[p] && !i_ack_n[p]) begin
                acked_ff[p] <= 1'b1;
                wait_ff[p]  <= i_hold;
            end else if (o_req[p] && acked_ff[p]) begin
                // a slow controller still lets go inside the quiet window
                if (wait_ff[p] == 2'd0) begin
                    o_req[p] <= 1'b0;
                end else begin
                    wait_ff[p] <= wait_ff[p] - 2'd1;
                end
            end
        end
    end
endmodule

// ===== verification/eip_ext_irq_bench.sv
// self-checking bench for the external interrupt pin logic
// assumes the bench plays the core, raising i_irq_taken at the falling edge where it sees an offer, so the offer is taken at the next rising edge
module eip_ext_irq_bench;
    import eip_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic       i_clock = 1'b0;
    logic       i_reset_n = 1'b0;
    logic [4:0] drv_req = 5'h0;
    logic       i_nonmaskable_req = 1'b0;
    logic       i_cascade_en = 1'b0;
    logic       i_int_enable = 1'b1;
    logic [4:0] i_source_mask = 5'h0;
    logic       i_irq_taken = 1'b0;
    logic       o_irq_valid, o_irq_cascade;
    logic [7:0] o_irq_type;
    logic       o_ack_zero_n, o_ack_zero_oe, o_ack_one_n, o_ack_one_oe;
    logic [1:0] raise = 2'b0, hold = 2'd0, cas_req, ack_n, cnt [2];
    logic       auto_take = 1'b1;
    logic [8:0] exp_o;
    logic [8:0] exp_offer [$];
    logic [7:0] exp_ack [$];
    logic [7:0] tbl [5] = '{TYPE_REQ_ZERO, TYPE_REQ_ONE, TYPE_REQ_TWO, TYPE_REQ_THR, TYPE_REQ_FOUR};
    int         errors = 0, total_checks = 0, cycles = 0, s;

    // the shared pins carry the acknowledge whenever the device drives them
    assign ack_n = {(o_ack_one_oe === 1'b1) ? o_ack_one_n : 1'b1,
                    (o_ack_zero_oe === 1'b1) ? o_ack_zero_n : 1'b1};

    eip_ext_irq i_eip_ext_irq (
        .i_clock           (i_clock),
        .i_reset_n         (i_reset_n),
        .i_ext_req_zero    (drv_req[0] | cas_req[0]),
        .i_ext_req_one     (drv_req[1] | cas_req[1]),
        .i_ext_req_two     ((o_ack_zero_oe === 1'b1) ? o_ack_zero_n : drv_req[2]),
        .i_ext_req_three   ((o_ack_one_oe === 1'b1) ? o_ack_one_n : drv_req[3]),
        .i_ext_req_four    (drv_req[4]),
        .i_nonmaskable_req (i_nonmaskable_req),
        .i_cascade_en      (i_cascade_en),
        .i_int_enable      (i_int_enable),
        .i_source_mask     (i_source_mask),
        .i_irq_taken       (i_irq_taken),
        .o_irq_valid       (o_irq_valid),
        .o_irq_type        (o_irq_type),
        .o_irq_cascade     (o_irq_cascade),
        .o_ack_zero_n      (o_ack_zero_n),
        .o_ack_zero_oe     (o_ack_zero_oe),
        .o_ack_one_n       (o_ack_one_n),
        .o_ack_one_oe      (o_ack_one_oe)
    );

    eip_cascade_ctrl i_eip_cascade_ctrl (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_raise   (raise),
        .i_hold    (hold),
        .i_ack_n   (ack_n),
        .o_req     (cas_req)
    );

    always #50 i_clock = ~i_clock;

    // ------------------------------------------------------------
    // compare tasks and closing report
    // ------------------------------------------------------------
    task automatic compare(input string nm, input logic [8:0] e, input logic [8:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h got %h", nm, e, g);
        end
    endtask

    task automatic chk_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
        compare(nm, {1'b0, e}, {1'b0, g});
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // watcher: takes offers and measures acknowledge pulses
    // ------------------------------------------------------------
    always @(negedge i_clock) begin
        if (i_irq_taken) begin
            i_irq_taken <= 1'b0;
        end else if (o_irq_valid === 1'b1 && auto_take) begin
            exp_o = (exp_offer.size() != 0) ? exp_offer.pop_front() : 9'h1FF;
            compare("offer", exp_o, {o_irq_cascade, o_irq_type});
            i_irq_taken <= 1'b1;
        end
        for (int p = 0; p < 2; p++) begin
            if (ack_n[p] === 1'b0) begin
                cnt[p] = cnt[p] + 2'd1;
            end else if (cnt[p] != 2'd0) begin
                exp_o[7:0] = (exp_ack.size() != 0) ? exp_ack.pop_front() : 8'hFF;
                chk_pin("ack_pulse", exp_o[7:0], {4'(p), 4'(cnt[p])});
                cnt[p] = 2'd0;
            end
        end
    end

    task automatic wait_valid;
        int n;
        n = 0;
        while (o_irq_valid !== 1'b1 && n < 40) begin
            @(negedge i_clock);
            n++;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cnt = '{2'd0, 2'd0};
        void'($urandom(32'hd27ed81f));
        repeat (4) @(negedge i_clock);
        chk_pin("rst_type", TYPE_NMI, o_irq_type);
        chk_pin("rst_flags", 8'h0C, {2'b0, o_irq_valid, o_irq_cascade, o_ack_zero_n,
                                     o_ack_one_n, o_ack_zero_oe, o_ack_one_oe});
        i_reset_n = 1'b1;
        repeat (4) @(negedge i_clock);
        // every source once, then random ones, other mask bits random
        for (int i = 0; i < 10; i++) begin
            s = (i < 5) ? i : int'($urandom % 5);
            i_source_mask = 5'($urandom) & ~(5'd1 << s);
            exp_offer.push_back({1'b0, tbl[s]});
            drv_req[s] = 1'b1;
            wait_valid();
            drv_req[s] = 1'b0;
            // the core masks the source on service; the synced level lingers for a few cycles
            i_source_mask = 5'h1F;
            repeat (8) @(negedge i_clock);
        end
        // masked, then globally disabled: any offer here is unexpected
        for (int k = 0; k < 2; k++) begin
            i_source_mask = (k == 0) ? 5'h1F : 5'h00;
            i_int_enable = (k == 0);
            drv_req = 5'h1F;
            repeat (12) @(negedge i_clock);
            drv_req = 5'h00;
            repeat (8) @(negedge i_clock);
        end
        // short nmi pulse must stay on offer although masked and disabled
        i_source_mask = 5'h1F;
        auto_take = 1'b0;
        i_nonmaskable_req = 1'b1;
        repeat (3) @(negedge i_clock);
        i_nonmaskable_req = 1'b0;
        repeat (20) @(negedge i_clock);
        chk_pin("nmi_held", 8'h01, {7'b0, o_irq_valid});
        exp_offer.push_back({1'b0, TYPE_NMI});
        auto_take = 1'b1;
        repeat (8) @(negedge i_clock);
        // cascade pairs, prompt then slow controller
        i_int_enable = 1'b1;
        i_source_mask = 5'h00;
        i_cascade_en = 1'b1;
        repeat (3) @(negedge i_clock);
        chk_pin("ack_oe", 8'h03, {6'b0, o_ack_one_oe, o_ack_zero_oe});
        for (int p = 0; p < 2; p++) begin
            hold = (p == 0) ? 2'd0 : 2'd2;
            exp_offer.push_back({1'b1, tbl[p]});
            exp_ack.push_back({4'(p), 4'(ACK_LOW_CYCLES)});
            raise[p] = 1'b1;
            @(negedge i_clock);
            raise = 2'b0;
            for (int n = 0; n < 60 && exp_ack.size() != 0; n++) @(negedge i_clock);
            repeat (10) @(negedge i_clock);
        end
        // released acknowledge pins read high for a few cycles through the synchroniser
        i_source_mask = 5'h1F;
        i_cascade_en = 1'b0;
        repeat (3) @(negedge i_clock);
        chk_pin("ack_oe", 8'h00, {6'b0, o_ack_one_oe, o_ack_zero_oe});
        chk_pin("pending", 8'h00, 8'(exp_offer.size() + exp_ack.size()));
        tally_and_finish();
    end
endmodule
